// *** src/wwd_top.sv ***
/*
 window watchdog with fault escalation to a backup-enable flag.
 assumes supply monitor, timing node and strobe arrive as async pins.
 Overview of operation is in the list below.
*/
// Overview of operation
// - no edge within period: late fault
// - edge in open window is good
// - three bad events assert backup enable
// - three good edges release backup enable
// - counter clears on reset rise, edge
// - counter held zero while reset low
// - counter starts at reset release
// - edges ignored while reset low
// - open window 50 or 75 percent
// - timing node low disables watchdog
// - reset held by supply, then timeout
// - closed-window edge is early fault
// - fault: reset low for hold time
// - period is closed plus open window
`timescale 1ns/10ps
`default_nettype none
module wwd_top
    import wwd_pkg::*;
#(
    parameter int             PERIOD_CYCLES = WATCHDOG_CYCLES,
    parameter int             HOLD_CYCLES   = RESET_HOLD_CYCLES,
    parameter wwd_window_type OPEN_WINDOW   = WWD_OPEN_50
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic srst,
    // pins from the supervised side
    input  wire logic service_strobe_in,
    input  wire logic supply_monitor_in,
    input  wire logic watchdog_timing_node,
    // open-drain outputs, low active
    output logic      reset_out_n,
    output logic      backup_enable_n
);
    // window boundaries in cycles from the last clear
    localparam int OPEN_CYCLES = (OPEN_WINDOW == WWD_OPEN_75) ?
        (PERIOD_CYCLES * 3) / 4 : PERIOD_CYCLES / 2;
    localparam logic [CNT_W-1:0] CLOSED_END =
        CNT_W'(PERIOD_CYCLES - OPEN_CYCLES);
    localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(PERIOD_CYCLES - 1);
    localparam logic [CNT_W-1:0] HOLD_LEN    = CNT_W'(HOLD_CYCLES);
    localparam logic [1:0]       TALLY_MAX   = 2'(TALLY_LIMIT);

    wwd_state_type    state_reg;
    wwd_state_type    state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [1:0]       bad_reg;
    logic [1:0]       bad_next;
    logic [1:0]       good_reg;
    logic [1:0]       good_next;
    logic             backup_next;
    logic             rst_next;
    logic             supply_ok;
    logic             enable_lvl;
    logic             strobe_fall;
    logic             hold_done;

    // pin synchronisers
    wwd_edge_sync u_strobe_sync (
        .mclk      (mclk),
        .srst      (srst),
        .pin_in    (service_strobe_in),
        .level_out (),
        .fall_out  (strobe_fall)
    );
    wwd_edge_sync u_supply_sync (
        .mclk      (mclk),
        .srst      (srst),
        .pin_in    (supply_monitor_in),
        .level_out (supply_ok),
        .fall_out  ()
    );
    wwd_edge_sync u_enable_sync (
        .mclk      (mclk),
        .srst      (srst),
        .pin_in    (watchdog_timing_node),
        .level_out (enable_lvl),
        .fall_out  ()
    );

    // decoding of events
    wire in_hold     = (state_reg == WWD_HOLD);
    wire watching    = (state_reg == WWD_WATCH) & enable_lvl;
    wire edge_taken  = watching & strobe_fall;
    wire early_fault = edge_taken & (cnt_reg < CLOSED_END);
    wire good_edge   = edge_taken & ~early_fault;
    wire late_fault  = watching & ~strobe_fall &
                       (cnt_reg == PERIOD_LAST);
    wire wd_fault    = early_fault | late_fault;
    wire hold_start  = wd_fault | ~supply_ok;
    wire release_now = in_hold & hold_done & supply_ok;

    wwd_hold_timer #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_hold (
        .mclk    (mclk),
        .srst    (srst),
        .restart (hold_start),
        .done    (hold_done)
    );

    // state sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            WWD_HOLD: begin
                if (release_now) begin
                    state_next = enable_lvl ? WWD_WATCH : WWD_IDLE;
                end
            end
            WWD_WATCH: begin
                if (hold_start) begin
                    state_next = WWD_HOLD;
                end else if (!enable_lvl) begin
                    state_next = WWD_IDLE;
                end
            end
            WWD_IDLE: begin
                if (!supply_ok) begin
                    state_next = WWD_HOLD;
                end else if (enable_lvl) begin
                    state_next = WWD_WATCH;
                end
            end
            default: begin
                state_next = WWD_HOLD;
            end
        endcase
    end

    // counter: zero in hold, zero on every clear, counts while watching
    assign cnt_next = (!watching || edge_taken) ? CNT_ZERO :
                      hold_start ? CNT_ZERO :
                      (cnt_reg == PERIOD_LAST) ? CNT_ZERO :
                      cnt_reg + CNT_ONE;

    // tallies of consecutive events
    assign bad_next  = good_edge ? TALLY_ZERO :
                       (wd_fault && bad_reg != TALLY_MAX) ?
                       bad_reg + TALLY_ONE : bad_reg;
    assign good_next = wd_fault ? TALLY_ZERO :
                       (good_edge && good_reg != TALLY_MAX) ?
                       good_reg + TALLY_ONE : good_reg;
    assign backup_next =
        (wd_fault && bad_reg == TALLY_MAX - TALLY_ONE) ? 1'b0 :
        (good_edge && good_reg == TALLY_MAX - TALLY_ONE) ? 1'b1 :
        backup_enable_n;
    assign rst_next = (state_next != WWD_HOLD);

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_reg       <= WWD_HOLD;
            cnt_reg         <= CNT_ZERO;
            bad_reg         <= TALLY_ZERO;
            good_reg        <= TALLY_ZERO;
            backup_enable_n <= 1'b1;
            reset_out_n     <= 1'b0;
        end else begin
            state_reg       <= state_next;
            cnt_reg         <= cnt_next;
            bad_reg         <= bad_next;
            good_reg        <= good_next;
            backup_enable_n <= backup_next;
            reset_out_n     <= rst_next;
        end
    end

    // checks
    property p_late_fault;
        @(posedge mclk) disable iff (srst)
        late_fault |=> !reset_out_n;
    endproperty
    a_late_fault: assert property (p_late_fault)
        else $error("late fault did not assert reset");

    property p_good_keeps;
        @(posedge mclk) disable iff (srst)
        good_edge && supply_ok |=> reset_out_n;
    endproperty
    a_good_keeps: assert property (p_good_keeps)
        else $error("good edge caused reset");

    property p_backup_set;
        @(posedge mclk) disable iff (srst)
        wd_fault && bad_reg == 2'h2 |=> !backup_enable_n;
    endproperty
    a_backup_set: assert property (p_backup_set)
        else $error("backup enable not asserted after three faults");

    property p_backup_rel;
        @(posedge mclk) disable iff (srst)
        $rose(backup_enable_n) |-> $past(good_edge) && $past(good_reg) == 2'h2;
    endproperty
    a_backup_rel: assert property (p_backup_rel)
        else $error("backup enable released without three good edges");

    property p_clear_edge;
        @(posedge mclk) disable iff (srst)
        edge_taken |=> cnt_reg == CNT_ZERO;
    endproperty
    a_clear_edge: assert property (p_clear_edge)
        else $error("counter not cleared by accepted edge");

    property p_hold_zero;
        @(posedge mclk) disable iff (srst)
        in_hold |-> cnt_reg == CNT_ZERO && !reset_out_n;
    endproperty
    a_hold_zero: assert property (p_hold_zero)
        else $error("counter moved during reset");

    property p_ignore_low;
        @(posedge mclk) disable iff (srst)
        !reset_out_n |-> !edge_taken;
    endproperty
    a_ignore_low: assert property (p_ignore_low)
        else $error("edge accepted while reset low");

    property p_supply;
        @(posedge mclk) disable iff (srst)
        !supply_ok |=> !reset_out_n [*2];
    endproperty
    a_supply: assert property (p_supply)
        else $error("reset released too soon after low supply");

    property p_early;
        @(posedge mclk) disable iff (srst)
        edge_taken && cnt_reg < CLOSED_END |=> !reset_out_n;
    endproperty
    a_early: assert property (p_early)
        else $error("early edge did not assert reset");

    // reset-low length for the hold check, saturates at the hold time
    logic [CNT_W-1:0] low_len_reg;
    logic [CNT_W-1:0] low_len_next;

    assign low_len_next = reset_out_n ? CNT_ZERO :
                          (low_len_reg == HOLD_LEN) ? low_len_reg :
                          low_len_reg + CNT_ONE;

    always_ff @(posedge mclk) begin
        if (srst) begin
            low_len_reg <= CNT_ZERO;
        end else begin
            low_len_reg <= low_len_next;
        end
    end

    property p_hold_len;
        @(posedge mclk) disable iff (srst)
        $rose(reset_out_n) |-> low_len_reg == HOLD_LEN;
    endproperty
    a_hold_len: assert property (p_hold_len)
        else $error("reset released before the hold time");

    property p_clear_rise;
        @(posedge mclk) disable iff (srst)
        $rose(reset_out_n) |-> cnt_reg == CNT_ZERO;
    endproperty
    a_clear_rise: assert property (p_clear_rise)
        else $error("counter not clear at reset release");

    property p_count_start;
        @(posedge mclk) disable iff (srst)
        $rose(reset_out_n) && watching && supply_ok && !strobe_fall
        |=> cnt_reg == CNT_ONE;
    endproperty
    a_count_start: assert property (p_count_start)
        else $error("counter did not start at reset release");

    property p_disabled;
        @(posedge mclk) disable iff (srst)
        !enable_lvl && supply_ok && reset_out_n
        |=> reset_out_n && cnt_reg == CNT_ZERO;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("disabled watchdog moved reset or counter");

    property p_period;
        @(posedge mclk) disable iff (srst)
        watching |-> cnt_reg <= PERIOD_LAST;
    endproperty
    a_period: assert property (p_period)
        else $error("counter ran past the period");

    property p_edge_once;
        @(posedge mclk) disable iff (srst)
        strobe_fall |=> !strobe_fall;
    endproperty
    a_edge_once: assert property (p_edge_once)
        else $error("strobe edge reported twice");

    property p_window;
        @(posedge mclk) disable iff (srst)
        edge_taken && cnt_reg >= CLOSED_END && supply_ok |=> reset_out_n;
    endproperty
    a_window: assert property (p_window)
        else $error("open-window edge caused reset");

    property p_bad_clear;
        @(posedge mclk) disable iff (srst)
        good_edge |=> bad_reg == TALLY_ZERO;
    endproperty
    a_bad_clear: assert property (p_bad_clear)
        else $error("good edge left bad tally set");

    property p_good_clear;
        @(posedge mclk) disable iff (srst)
        wd_fault |=> good_reg == TALLY_ZERO;
    endproperty
    a_good_clear: assert property (p_good_clear)
        else $error("fault left good tally set");

    property p_backup_hold;
        @(posedge mclk) disable iff (srst)
        !backup_enable_n && !good_edge |=> !backup_enable_n;
    endproperty
    a_backup_hold: assert property (p_backup_hold)
        else $error("backup enable released without a good edge");
endmodule
`default_nettype wire

// *** src/wwd_pkg.sv ***
/*
 window watchdog package: timing constants, window choices, states.
 assumes a single 20 mhz clock, period 50 ns.
*/
package wwd_pkg;
    localparam int        CLK_PERIOD_NS       = 50;
    // plain defaults, set per board
    localparam int        WATCHDOG_PERIOD_US  = 10000;
    localparam int        RESET_HOLD_TIME_US  = 4000;
    localparam int        WATCHDOG_CYCLES     =
        (WATCHDOG_PERIOD_US * 1000) / CLK_PERIOD_NS;
    localparam int        RESET_HOLD_CYCLES   =
        (RESET_HOLD_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int        CNT_W               = 24;
    localparam int        TALLY_LIMIT         = 3;
    localparam logic [1:0] TALLY_ZERO         = 2'h0;
    localparam logic [1:0] TALLY_ONE          = 2'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO     = 24'h000000;
    localparam logic [CNT_W-1:0] CNT_ONE      = 24'h000001;

    typedef enum logic {
        WWD_OPEN_50 = 1'b0,
        WWD_OPEN_75 = 1'b1
    } wwd_window_type;

    typedef enum logic [1:0] {
        WWD_HOLD  = 2'b00,
        WWD_WATCH = 2'b01,
        WWD_IDLE  = 2'b10
    } wwd_state_type;
endpackage

// *** src/wwd_edge_sync.sv ***
/*
 two-flop synchroniser with falling-edge pulse.
 assumes an asynchronous pin input and the block clock.
*/
`timescale 1ns/10ps
`default_nettype none
module wwd_edge_sync
    import wwd_pkg::*;
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic srst,
    // pin side
    input  wire logic pin_in,
    // synchronised outputs
    output logic      level_out,
    output logic      fall_out
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // first flop only feeds the second
    always_ff @(posedge mclk) begin
        if (srst) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            last_reg <= 1'b1;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign level_out = sync_reg;
    assign fall_out  = last_reg & ~sync_reg;
endmodule
`default_nettype wire

// *** src/wwd_hold_timer.sv ***
/*
 reset hold timer: counts the hold period after a start pulse.
 assumes restart comes from the same clock; while restart is held high, the count stays at zero.
*/
`timescale 1ns/10ps
`default_nettype none
module wwd_hold_timer
    import wwd_pkg::*;
#(
    parameter int HOLD_CYCLES = RESET_HOLD_CYCLES
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic srst,
    // control
    input  wire logic restart,
    // status
    output logic      done
);
    localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 1);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    wire              at_end = (cnt_reg == HOLD_LAST);

    assign cnt_next = restart ? CNT_ZERO :
                      (at_end ? cnt_reg : cnt_reg + CNT_ONE);
    assign done     = at_end & ~restart;

    always_ff @(posedge mclk) begin
        if (srst) begin
            cnt_reg <= CNT_ZERO;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule
`default_nettype wire

// *** verification/wwd_mcu_model.sv ***
/*
 processor model: drives the watchdog service strobe pin.
 assumes the bench calls service() from its main sequence.
*/
`timescale 1ns/10ps
`default_nettype none
module wwd_mcu_model (
    // clock
    input  wire logic mclk,
    // strobe pin
    output logic      strobe_pin
);
    // pin never floats, idles high
    initial strobe_pin = 1'b1;
    // one falling edge d cycles on, pulse held 6 cycles
    task automatic service(input int d);
        repeat (d) @(negedge mclk);
        strobe_pin = 1'b0;
        repeat (6) @(negedge mclk);
        strobe_pin = 1'b1;
    endtask
endmodule
`default_nettype wire

// *** verification/wwd_top_tb.sv ***
/*
 self-checking bench for the window watchdog.
 assumes the design under src/ and the processor model.
*/
`timescale 1ns/10ps
`default_nettype none
module wwd_top_tb;
    import wwd_pkg::*;
    localparam int PER  = 40;
    localparam int HOLD = 16;
    typedef struct {
        int lo;
        int hi;
    } wwd_note_type;
    logic         mclk;
    logic         srst;
    logic         supply_monitor_in;
    logic         watchdog_timing_node;
    logic         strobe;
    logic         reset_out_n;
    logic         backup_enable_n;
    logic         strobe_d = 1'b1;
    logic         rst_d = 1'b0;
    int           num_errors = 0;
    int           n_checks = 0;
    int           hi_cnt = 0;
    int           lo_cnt = 0;
    wwd_note_type notes[$];

    wwd_top #(
        .PERIOD_CYCLES (PER),
        .HOLD_CYCLES   (HOLD),
        .OPEN_WINDOW   (WWD_OPEN_50)
    ) wwd_top_i (
        .mclk                 (mclk),
        .srst                 (srst),
        .service_strobe_in    (strobe),
        .supply_monitor_in    (supply_monitor_in),
        .watchdog_timing_node (watchdog_timing_node),
        .reset_out_n          (reset_out_n),
        .backup_enable_n      (backup_enable_n)
    );
    wwd_mcu_model wwd_mcu_model_i (
        .mclk       (mclk),
        .strobe_pin (strobe)
    );

    initial mclk = 1'b0;
    always #25 mclk = ~mclk;

    task automatic stop_test;
        n_checks++;
        if (notes.size() != 0) begin
            num_errors++;
            $display("unexpected notes left: expected 0, seen %0d",
                     notes.size());
        end
        $display("checks %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check_range(input string what, input int v,
                               input wwd_note_type n);
        n_checks++;
        if (v < n.lo || v > n.hi) begin
            num_errors++;
            $display("unexpected %s: expected %0d..%0d, seen %0d",
                     what, n.lo, n.hi, v);
        end
    endtask

    task automatic check_bit(input string what, input logic exp);
        logic seen;
        seen = (what == "backup") ? backup_enable_n : reset_out_n;
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %b, seen %b", what, exp, seen);
        end
    endtask

    // a fault: high time before it, then the low time
    task automatic note_fault(input int lo, input int hi);
        notes.push_back('{lo, hi});
        notes.push_back('{HOLD, HOLD + 6});
    endtask

    task automatic wait_level(input logic v);
        for (int i = 0; i < 80 && reset_out_n !== v; i++) begin
            @(negedge mclk);
        end
        if (reset_out_n !== v) begin
            num_errors++;
            $display("unexpected wait: expected reset %b, seen %b",
                     v, reset_out_n);
            stop_test();
        end
    endtask

    task automatic good_edge;
        wwd_mcu_model_i.service(20 + $urandom % 6);
        check_bit("reset", 1'b1);
    endtask

    // early or late fault, with an ignored edge while reset is low
    task automatic bad_event(input bit early);
        if (early) begin
            note_fault(2, 7);
            wwd_mcu_model_i.service(5);
        end else begin
            note_fault(37, 46);
        end
        wait_level(1'b0);
        wwd_mcu_model_i.service(1);
        wait_level(1'b1);
    endtask

    // watches reset edges, takes the oldest note for each
    always @(posedge mclk) begin
        wwd_note_type n;
        strobe_d <= strobe;
        rst_d <= reset_out_n;
        hi_cnt <= (!reset_out_n || (strobe_d && !strobe)) ? 0 : hi_cnt + 1;
        lo_cnt <= (reset_out_n || !supply_monitor_in) ? 0 : lo_cnt + 1;
        if (!srst && rst_d !== reset_out_n) begin
            if (notes.size() == 0) begin
                num_errors++;
                n_checks++;
                $display("unexpected reset edge: expected none, seen %b",
                         reset_out_n);
            end else begin
                n = notes.pop_front();
                check_range(reset_out_n ? "low time" : "high time",
                            reset_out_n ? lo_cnt : hi_cnt, n);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        $display("unexpected timeout: expected end, seen hang");
        stop_test();
    end

    initial begin
        srst = 1'b1;
        supply_monitor_in = 1'b0;
        watchdog_timing_node = 1'b1;
        void'($urandom(70129));
        repeat (20) @(posedge mclk);
        @(negedge mclk);
        srst = 1'b0;
        repeat (5) @(negedge mclk);
        notes.push_back('{HOLD, HOLD + 6});
        supply_monitor_in = 1'b1;
        wait_level(1'b1);
        check_bit("backup", 1'b1);
        $display("test power_up done");
        for (int i = 0; i < 3; i++) begin
            good_edge();
        end
        check_bit("backup", 1'b1);
        $display("test good_edges done");
        bad_event(1'b1);
        check_bit("backup", 1'b1);
        bad_event(1'b0);
        check_bit("backup", 1'b1);
        bad_event(1'b1);
        check_bit("backup", 1'b0);
        $display("test escalation done");
        good_edge();
        good_edge();
        check_bit("backup", 1'b0);
        good_edge();
        repeat (4) @(negedge mclk);
        check_bit("backup", 1'b1);
        $display("test recovery done");
        watchdog_timing_node = 1'b0;
        wwd_mcu_model_i.service(5);
        repeat (3 * PER) @(negedge mclk);
        check_bit("reset", 1'b1);
        note_fault(0, 2000);
        supply_monitor_in = 1'b0;
        repeat (10) @(negedge mclk);
        supply_monitor_in = 1'b1;
        wait_level(1'b1);
        check_bit("backup", 1'b1);
        $display("test disabled_and_supply done");
        repeat (2) @(negedge mclk);
        stop_test();
    end
endmodule
`default_nettype wire
